// >>> design/fes_sequencer.v
// Purpose: erase command sequencer for the main flash array
// Assumes: bus strobes are single-cycle and synchronous to sys_clk
// Notes: array contents are modelled only by sector status
// Functional notes
// - Bulk erase needs six correct writes; a wrong byte returns to array read.
// - Error bit goes high when erase retries run out.
// - Targeted bytes are pre-programmed to 00h, then erased to FFh.
// - Writes are ignored while bulk erase runs.
// - Sector confirms inside the 100 us window add sectors.
// - Each accepted sector confirm restarts the window.
// - Erase window bit low while counting, high when erasing.
// - Other writes during the window cancel the erase, except unlock prefix writes.
// - During sector erase only reset and suspend are taken.
// - Suspend is B0h with a sector select, only during sector erase.
// - Suspend during the window also ends the window.
// - Toggle bit stops within 0.1 to 15 us after suspend.
// - Suspended reads of erasing sectors are undefined, others valid.
// - Suspended: no program, only resume and reset accepted.
// - Reset while suspended abandons the erase.
// - Resume is 30h with a sector select; erase continues.
// - Reset is one or three writes and returns to idle.
// - Sector erase confirms to protected sectors are silently ignored; bulk erase skips them.
// - Verify on protected sectors returns the stored data.
// - Protection bits are readable by the host, never writable.
// - Main protection register holds one bit per sector.
// - Secondary register: flag bit 7, bits 6-4 zero, bits 3-0 protection.
// - Poll bit reads zero while erase runs.
// - Toggle bit flips per status read while busy.
`timescale 1ns/1ps
`default_nettype none
`include "fes_defines.vh"
module fes_sequencer #(
	parameter WINDOW_CYC = `FES_WINDOW_CYC, // Sector collection window
	parameter ERASE_CYC = `FES_ERASE_CYC // Cycles per erase phase
) (
	input wire sys_clk, // 250 MHz clock
	input wire rst_b, // Active low async reset
	input wire [7:0] main_sector_select, // Main flash sector selects
	input wire [3:0] secondary_sector_select, // Secondary sector selects
	input wire config_register_space, // Config register select
	input wire bus_wr, // Write strobe
	input wire bus_rd, // Read strobe
	input wire [11:0] bus_addr, // Low address
	input wire [7:0] bus_wdata, // Write data
	input wire [7:0] array_rdata, // Array read data
	input wire [7:0] main_prot_cfg, // Protection from config port
	input wire [3:0] sec_prot_cfg, // Secondary protection from config port
	input wire security_cfg, // Security flag from config port
	input wire erase_fail, // Array reports a failed erase pass
	output reg [7:0] bus_rdata, // Read data
	output reg busy, // Embedded algorithm active
	output reg [7:0] erase_sectors, // Sectors being erased
	output reg [7:0] cell_data, // Data driven to cells
	output reg cell_write, // Cell program or erase strobe
	output reg suspended // Erase suspended
);
	localparam S_READ = 7'h01;
	localparam S_WINDOW = 7'h02;
	localparam S_PREPROG = 7'h04;
	localparam S_ERASE = 7'h08;
	localparam S_SUSPWAIT = 7'h10;
	localparam S_SUSP = 7'h20;
	localparam S_BULK = 7'h40;
	localparam [23:0] WIN_CNT = WINDOW_CYC;
	localparam [23:0] ERS_CNT = ERASE_CYC;
	localparam [23:0] SUSP_CNT = `FES_SUSP_CYC;
	// Retry budget, loaded on each new erase
	localparam [2:0] TRIES_INIT = `FES_MAX_TRIES - 1;

	////////////////////////////////////////////////////////////////
	// Reset release
	reg rst_s1_reg;
	reg rst_s2_reg;
	wire rst_n;
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	////////////////////////////////////////////////////////////////
	// Decoding
	reg [6:0] state_reg;
	reg [6:0] state_next;
	reg [7:0] sect_reg;
	reg [7:0] sect_next;
	reg [2:0] tries_reg;
	reg error_reg;
	reg toggle_reg;
	reg bulk_reg;
	reg preprog_done_reg;
	wire flash_sel = |main_sector_select;
	wire fl_wr = bus_wr && flash_sel && !config_register_space;
	wire [2:0] stage;
	wire step_ok;
	wire is_reset = fl_wr && (bus_wdata == `FES_CMD_RESET);
	wire is_susp = fl_wr && (bus_wdata == `FES_CMD_SUSPEND);
	wire is_resume = fl_wr && (bus_wdata == `FES_CMD_RESUME);
	wire [7:0] target_ok = main_sector_select & ~main_prot_cfg;
	wire final_wr = fl_wr && (stage == 3'h5);
	wire bulk_cmd = final_wr && (bus_wdata == `FES_CMD_BULK);
	wire sect_cmd = final_wr && (bus_wdata == `FES_CMD_SECTOR) && (|target_ok);
	wire dec_wr = fl_wr && (state_reg == S_READ || state_reg == S_WINDOW);
	wire dec_clear = !(state_reg == S_READ || state_reg == S_WINDOW);

	// Unlock prefix tracking, configurable bytes
	fes_cmd_decode u_dec (
		.clk(sys_clk),
		.rst_n(rst_n),
		.wr(dec_wr),
		.clear(dec_clear),
		.addr(bus_addr),
		.data(bus_wdata),
		.stage(stage),
		.step_ok(step_ok)
	);

	////////////////////////////////////////////////////////////////
	// Timers
	reg win_load;
	reg win_stop;
	reg ph_load;
	reg ph_stop;
	reg [23:0] ph_count;
	wire win_run;
	wire win_done;
	wire ph_run;
	wire ph_done;
	// Window timer, reloaded by each accepted confirm
	fes_timer u_win (
		.clk(sys_clk),
		.rst_n(rst_n),
		.load(win_load),
		.stop(win_stop),
		.count(WIN_CNT),
		.running(win_run),
		.done(win_done)
	);
	// Phase timer for pre-program, erase and suspend wait
	fes_timer u_phase (
		.clk(sys_clk),
		.rst_n(rst_n),
		.load(ph_load),
		.stop(ph_stop),
		.count(ph_count),
		.running(ph_run),
		.done(ph_done)
	);

	////////////////////////////////////////////////////////////////
	// Next state
	always @* begin
		state_next = state_reg;
		sect_next = sect_reg;
		win_load = 1'b0;
		win_stop = 1'b0;
		ph_load = 1'b0;
		ph_stop = 1'b0;
		ph_count = ERS_CNT;
		case (state_reg)
			S_READ: begin
				if (bulk_cmd && (|(~main_prot_cfg))) begin
					sect_next = ~main_prot_cfg;
					state_next = S_PREPROG;
					ph_load = 1'b1;
				end else if (sect_cmd) begin
					sect_next = target_ok;
					state_next = S_WINDOW;
					win_load = 1'b1;
				end else if (is_reset) begin
					// Reset drops a failed erase left on view
					sect_next = 8'h00;
				end
			end
			S_WINDOW: begin
				if (is_susp) begin
					win_stop = 1'b1;
					state_next = S_SUSPWAIT;
					ph_count = SUSP_CNT;
					ph_load = 1'b1;
				end else if (fl_wr && (bus_wdata == `FES_CMD_SECTOR) && (|target_ok)) begin
					sect_next = sect_reg | target_ok;
					win_load = 1'b1;
				end else if (fl_wr && !is_resume && !(step_ok && stage < 3'h5)) begin
					win_stop = 1'b1;
					sect_next = 8'h00;
					state_next = S_READ;
				end else if (win_done) begin
					state_next = S_PREPROG;
					ph_load = 1'b1;
				end
			end
			S_PREPROG: begin
				if (!bulk_reg && is_susp) begin
					ph_count = SUSP_CNT;
					ph_load = 1'b1;
					state_next = S_SUSPWAIT;
				end else if (!bulk_reg && is_reset) begin
					ph_stop = 1'b1;
					sect_next = 8'h00;
					state_next = S_READ;
				end else if (ph_done) begin
					state_next = S_ERASE;
					ph_load = 1'b1;
				end
			end
			S_ERASE: begin
				if (!bulk_reg && is_susp) begin
					ph_count = SUSP_CNT;
					ph_load = 1'b1;
					state_next = S_SUSPWAIT;
				end else if (!bulk_reg && is_reset) begin
					ph_stop = 1'b1;
					sect_next = 8'h00;
					state_next = S_READ;
				end else if (ph_done) begin
					if (erase_fail && tries_reg != 3'h0) begin
						ph_load = 1'b1;
					end else begin
						// Failed sectors stay selected so the error bit can be read
						if (!erase_fail)
							sect_next = 8'h00;
						state_next = S_READ;
					end
				end
			end
			S_SUSPWAIT: begin
				if (ph_done)
					state_next = S_SUSP;
			end
			S_SUSP: begin
				// Only reset and resume are taken, programming is refused
				if (is_reset) begin
					sect_next = 8'h00;
					state_next = S_READ;
				end else if (is_resume) begin
					state_next = preprog_done_reg ? S_ERASE : S_PREPROG;
					ph_load = 1'b1;
				end
			end
			S_BULK: state_next = S_READ;
			default: state_next = S_READ;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// State and status registers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_READ;
			sect_reg <= 8'h00;
			tries_reg <= 3'h0;
			error_reg <= 1'b0;
			bulk_reg <= 1'b0;
			preprog_done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sect_reg <= sect_next;
			if (state_reg == S_READ && state_next == S_PREPROG)
				bulk_reg <= 1'b1;
			else if (state_next == S_READ || state_next == S_WINDOW)
				bulk_reg <= 1'b0;
			if (state_reg == S_PREPROG && state_next == S_ERASE)
				preprog_done_reg <= 1'b1;
			else if (state_next == S_READ || state_next == S_WINDOW)
				preprog_done_reg <= 1'b0;
			if (state_next == S_PREPROG && state_reg != S_SUSP) begin
				tries_reg <= TRIES_INIT;
				error_reg <= 1'b0;
			end else if (state_reg == S_ERASE && ph_done && erase_fail) begin
				if (tries_reg == 3'h0)
					error_reg <= 1'b1;
				else
					tries_reg <= tries_reg - 3'h1;
			end else if (is_reset && state_next == S_READ) begin
				error_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path
	wire erasing = (state_reg == S_PREPROG) || (state_reg == S_ERASE);
	wire run_busy = erasing || (state_reg == S_SUSPWAIT);
	wire hit_erasing = |(main_sector_select & sect_reg);
	wire [7:0] status_byte = {1'b0, toggle_reg, error_reg, 1'b0, erasing, 3'h0};
	wire [7:0] window_byte = {1'b0, toggle_reg, 1'b0, 1'b0, 1'b0, 3'h0};
	reg [7:0] rd_next;
	always @* begin
		rd_next = bus_rdata;
		if (bus_rd) begin
			if (config_register_space && bus_addr[7:0] == `FES_REG_MAIN_PROT)
				rd_next = main_prot_cfg;
			else if (config_register_space && bus_addr[7:0] == `FES_REG_SEC_PROT)
				rd_next = {security_cfg, 3'h0, sec_prot_cfg};
			else if (config_register_space)
				rd_next = 8'h00;
			else if (state_reg == S_WINDOW && hit_erasing)
				rd_next = window_byte;
			else if (run_busy && hit_erasing)
				rd_next = status_byte;
			else if (state_reg == S_SUSP && hit_erasing)
				rd_next = `FES_CELL_ERASED;
			// Failed erase keeps its status readable until reset
			else if (state_reg == S_READ && error_reg && hit_erasing)
				rd_next = status_byte;
			else
				rd_next = array_rdata;
		end
	end

	// Toggle flips on each busy status read
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_reg <= 1'b0;
			bus_rdata <= 8'h00;
			busy <= 1'b0;
			erase_sectors <= 8'h00;
			cell_data <= 8'h00;
			cell_write <= 1'b0;
			suspended <= 1'b0;
		end else begin
			if (bus_rd && hit_erasing && (run_busy || state_reg == S_WINDOW))
				toggle_reg <= ~toggle_reg;
			bus_rdata <= rd_next;
			busy <= run_busy || (state_reg == S_WINDOW);
			erase_sectors <= sect_reg;
			cell_data <= (state_reg == S_PREPROG) ? `FES_CELL_ZERO : `FES_CELL_ERASED;
			cell_write <= erasing && ph_done;
			suspended <= (state_reg == S_SUSP);
		end
	end
endmodule // fes_sequencer
`default_nettype wire

// >>> design/fes_defines.vh
// Purpose: constants for the flash erase sequencer
// Assumes: 250 MHz sys_clk
// Notes: command bytes and addresses are configurable
`ifndef FES_DEFINES_VH
`define FES_DEFINES_VH
`define FES_CMD_A1 12'h555
`define FES_CMD_A2 12'hAAA
`define FES_CMD_D1 8'hAA
`define FES_CMD_D2 8'h55
`define FES_CMD_ERASE 8'h80
`define FES_CMD_BULK 8'h10
`define FES_CMD_SECTOR 8'h30
`define FES_CMD_SUSPEND 8'hB0
`define FES_CMD_RESUME 8'h30
`define FES_CMD_RESET 8'hF0
`define FES_CLK_MHZ 250
`define FES_WINDOW_US 100
`define FES_WINDOW_CYC (`FES_WINDOW_US * `FES_CLK_MHZ)
`define FES_SUSP_NS 100
`define FES_SUSP_CYC ((`FES_SUSP_NS * `FES_CLK_MHZ + 999) / 1000)
`define FES_ERASE_CYC 20000
`define FES_MAX_TRIES 4
`define FES_CELL_ZERO 8'h00
`define FES_CELL_ERASED 8'hFF
`define FES_REG_MAIN_PROT 8'hC0
`define FES_REG_SEC_PROT 8'hC2
`define FES_SEC_FLAG_BIT 7
`endif

// >>> design/fes_timer.v
// Purpose: loadable down counter with done pulse
// Assumes: synchronous reset-free use under rst_n
// Notes: load wins over counting
`timescale 1ns/1ps
`default_nettype none
module fes_timer (
	input wire clk, // Clock
	input wire rst_n, // Active low reset
	input wire load, // Restart count
	input wire stop, // Abandon count
	input wire [23:0] count, // Start value
	output reg running, // Counting
	output reg done // Expiry pulse
);
	reg [23:0] cnt_reg;
	// Count down, flag expiry
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 24'h000000;
			running <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_reg <= count;
				running <= 1'b1;
			end else if (stop) begin
				running <= 1'b0;
			end else if (running) begin
				if (cnt_reg <= 24'h000001) begin
					running <= 1'b0;
					done <= 1'b1;
				end
				cnt_reg <= cnt_reg - 24'h000001;
			end
		end
	end
endmodule // fes_timer
`default_nettype wire

// >>> design/fes_cmd_decode.v
// Purpose: tracks the unlock prefix of flash commands
// Assumes: one write strobe per bus write
// Notes: any wrong byte clears the prefix
`timescale 1ns/1ps
`default_nettype none
`include "fes_defines.vh"
module fes_cmd_decode (
	input wire clk, // Clock
	input wire rst_n, // Active low reset
	input wire wr, // Flash write strobe
	input wire clear, // Drop progress
	input wire [11:0] addr, // Low address
	input wire [7:0] data, // Write data
	output reg [2:0] stage, // Accepted writes so far
	output wire step_ok // Current write matches
);
	// Expected write for each stage
	function match;
		input [2:0] s;
		input [11:0] a;
		input [7:0] d;
		begin
			case (s)
				3'h0, 3'h3: match = (a == `FES_CMD_A1) && (d == `FES_CMD_D1);
				3'h1, 3'h4: match = (a == `FES_CMD_A2) && (d == `FES_CMD_D2);
				3'h2: match = (a == `FES_CMD_A1) && (d == `FES_CMD_ERASE);
				default: match = 1'b0;
			endcase
		end
	endfunction
	assign step_ok = match(stage, addr, data);
	// Advance on a correct byte, restart otherwise
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage <= 3'h0;
		end else if (clear) begin
			stage <= 3'h0;
		end else if (wr) begin
			if (stage < 3'h5 && step_ok)
				stage <= stage + 3'h1;
			else
				stage <= 3'h0;
		end
	end
endmodule // fes_cmd_decode
`default_nettype wire

// >>> tb/fes_seq_monitor.sv
// Purpose: port checker for the erase sequencer
// Assumes: single sys_clk domain
// Notes: armed three edges after reset release
`timescale 1ns/1ps
`default_nettype none
module fes_seq_monitor (
	input wire sys_clk, // Clock
	input wire rst_b, // Active low reset
	input wire [7:0] main_sector_select, // Sector selects
	input wire config_register_space, // Config select
	input wire bus_wr, // Write strobe
	input wire bus_rd, // Read strobe
	input wire [11:0] bus_addr, // Address
	input wire [7:0] main_prot_cfg, // Main protection
	input wire [3:0] sec_prot_cfg, // Secondary protection
	input wire security_cfg, // Security flag
	input wire [7:0] bus_rdata, // Read data
	input wire busy, // Algorithm active
	input wire [7:0] erase_sectors, // Erasing sectors
	input wire cell_write, // Cell strobe
	input wire suspended // Suspended
);
	logic [2:0] live_reg;
	// Follows the internal reset release, one edge later
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) live_reg <= 3'h0;
		else live_reg <= {live_reg[1:0], 1'b1};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!live_reg[2]);
	chk_main_prot_read: assert property (
		bus_rd && config_register_space && bus_addr[7:0] == 8'hC0 |=> bus_rdata == $past(main_prot_cfg))
		else $error("main protection read wrong");
	chk_sec_prot_read: assert property (
		bus_rd && config_register_space && bus_addr[7:0] == 8'hC2
		|=> bus_rdata == {$past(security_cfg), 3'h0, $past(sec_prot_cfg)}) else $error("secondary read wrong");
	chk_rdata_holds: assert property (!bus_rd |=> $stable(bus_rdata)) else $error("read data moved");
	chk_poll_low: assert property (
		bus_rd && busy && !config_register_space && |(main_sector_select & erase_sectors) |=> !bus_rdata[7])
		else $error("poll bit high while busy");
	chk_prot_skip: assert property (busy |-> (erase_sectors & main_prot_cfg) == 8'h00)
		else $error("protected sector erased");
	chk_suspend_idle: assert property (suspended |-> !busy) else $error("busy while suspended");
	chk_suspend_wait: assert property ($rose(suspended) |-> $past(busy)) else $error("suspend without wait");
	chk_cell_pulse: assert property (cell_write |=> !cell_write) else $error("cell strobe too long");
	chk_sectors_hold: assert property (
		busy && $past(busy) && !$past(bus_wr, 2) |-> $stable(erase_sectors)) else $error("sectors changed unasked");
endmodule // fes_seq_monitor
bind fes_sequencer fes_seq_monitor u_mon (.sys_clk(sys_clk), .rst_b(rst_b),
	.main_sector_select(main_sector_select), .config_register_space(config_register_space), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_addr(bus_addr), .main_prot_cfg(main_prot_cfg), .sec_prot_cfg(sec_prot_cfg),
	.security_cfg(security_cfg), .bus_rdata(bus_rdata), .busy(busy), .erase_sectors(erase_sectors),
	.cell_write(cell_write), .suspended(suspended));
`default_nettype wire

// >>> tb/fes_mcu_model.sv
// Purpose: host bus master model
// Assumes: drives on falling edges
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
`default_nettype none
module fes_mcu_model (
	input wire logic sys_clk, // Clock
	input wire logic [7:0] bus_rdata, // Read data
	output logic [7:0] main_sector_select, // Sector selects
	output logic config_register_space, // Config select
	output logic bus_wr, // Write strobe
	output logic bus_rd, // Read strobe
	output logic [11:0] bus_addr, // Address
	output logic [7:0] bus_wdata // Write data
);
	// Idle bus at time zero
	initial begin
		{main_sector_select, config_register_space, bus_wr, bus_rd} = 11'h000;
		bus_addr = 12'h000;
		bus_wdata = 8'h00;
	end
	// One strobe cycle, then release with inverted address and data
	task automatic cycle(input logic [7:0] sel, input logic cfg, input logic wr, input logic [11:0] a,
		input logic [7:0] d);
		@(negedge sys_clk);
		{main_sector_select, config_register_space, bus_wr, bus_rd} = {sel, cfg, wr, !wr};
		bus_addr = a;
		bus_wdata = d;
		@(negedge sys_clk);
		{main_sector_select, config_register_space, bus_wr, bus_rd} = 11'h000;
		bus_addr = ~a;
		bus_wdata = ~d;
		// Let registered outputs settle before the caller looks
		@(negedge sys_clk);
	endtask
	task automatic write(input logic [7:0] sel, input logic [11:0] a, input logic [7:0] d);
		cycle(sel, 1'b0, 1'b1, a, d);
	endtask
	task automatic read(input logic [7:0] sel, input logic cfg, input logic [11:0] a, output logic [7:0] d);
		cycle(sel, cfg, 1'b0, a, 8'h00);
		d = bus_rdata;
	endtask
	// Six-write erase command, last byte picks bulk or sector
	task automatic cmd(input logic [7:0] sel, input logic [7:0] last);
		write(sel, 12'h555, 8'hAA);
		write(sel, 12'hAAA, 8'h55);
		write(sel, 12'h555, 8'h80);
		write(sel, 12'h555, 8'hAA);
		write(sel, 12'hAAA, 8'h55);
		write(sel, 12'h555, last);
	endtask
endmodule // fes_mcu_model
`default_nettype wire

// >>> tb/test_flash_erase_sequencer.sv
// Purpose: self-checking bench for the erase sequencer
// Assumes: short window and phase counts
// Notes: host traffic goes through the bus model
`timescale 1ns/1ps
`default_nettype none
module test_flash_erase_sequencer;
	logic sys_clk = 1'b0, rst_b = 1'b0, config_register_space, bus_wr, bus_rd, busy, cell_write, suspended;
	logic security_cfg = 1'b1, erase_fail = 1'b0;
	logic [7:0] main_sector_select, bus_wdata, bus_rdata, erase_sectors, cell_data, d, e;
	logic [7:0] array_rdata = 8'h5A, main_prot_cfg = 8'h81;
	logic [3:0] sec_prot_cfg = 4'hA;
	logic [11:0] bus_addr;
	int failures = 0, samples_checked = 0, pulses = 0;
	always #2 sys_clk = ~sys_clk;
	// Count cell strobes
	always @(posedge sys_clk) if (cell_write === 1'b1) pulses <= pulses + 1;
	fes_sequencer #(.WINDOW_CYC(50), .ERASE_CYC(100)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.main_sector_select(main_sector_select), .secondary_sector_select(4'h0),
		.config_register_space(config_register_space), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .array_rdata(array_rdata), .main_prot_cfg(main_prot_cfg),
		.sec_prot_cfg(sec_prot_cfg), .security_cfg(security_cfg), .erase_fail(erase_fail),
		.bus_rdata(bus_rdata), .busy(busy), .erase_sectors(erase_sectors), .cell_data(cell_data),
		.cell_write(cell_write), .suspended(suspended));
	fes_mcu_model mcu (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .main_sector_select(main_sector_select),
		.config_register_space(config_register_space), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for idle (sus=0) or suspended (sus=1)
	task automatic wait_st(input bit sus);
		int n;
		for (n = 0; n < 4000 && (sus ? suspended !== 1'b1 : busy !== 1'b0); n++) @(negedge sys_clk);
		// Running out of time counts as a mismatch
		if (n == 4000) begin
			failures++;
			print_verdict();
		end
	endtask
	task automatic print_verdict();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		mcu.read(8'h00, 1'b1, 12'h0C0, d);
		check(d, 8'h81);
		mcu.read(8'h00, 1'b1, 12'h0C2, d);
		check(d, 8'h8A);
		mcu.cycle(8'h00, 1'b1, 1'b1, 12'h0C0, 8'h00);
		mcu.read(8'h00, 1'b1, 12'h0C0, d);
		check(d, 8'h81);
		security_cfg = 1'b0;
		mcu.read(8'h00, 1'b1, 12'h0C2, d);
		check(d, 8'h0A);
	endtask
	task automatic t_bulk();
		int p0;
		mcu.cmd(8'h02, 8'h11);
		check(8'(busy), 8'h00);
		mcu.read(8'h02, 1'b0, 12'h000, d);
		check(d, 8'h5A);
		p0 = pulses;
		mcu.cmd(8'h02, 8'h10);
		check(erase_sectors, 8'h7E);
		mcu.read(8'h02, 1'b0, 12'h000, d);
		mcu.read(8'h02, 1'b0, 12'h000, e);
		check(8'(d[7]), 8'h00);
		check(8'(d[6] ^ e[6]), 8'h01);
		check(cell_data, 8'h00);
		mcu.write(8'h02, 12'h000, 8'hB0);
		check(8'(suspended), 8'h00);
		wait_st(1'b0);
		check(8'(busy), 8'h00);
		check(8'(pulses - p0), 8'h02);
		check(cell_data, 8'hFF);
		mcu.read(8'h02, 1'b0, 12'h000, d);
		mcu.read(8'h02, 1'b0, 12'h000, e);
		check(8'(d[6] ^ e[6]), 8'h00);
	endtask
	task automatic t_sector();
		mcu.cmd(8'h02, 8'h30);
		mcu.read(8'h02, 1'b0, 12'h000, d);
		check(8'(d[3]), 8'h00);
		repeat (30) @(negedge sys_clk);
		mcu.write(8'h04, 12'h000, 8'h30);
		check(erase_sectors, 8'h06);
		repeat (40) @(negedge sys_clk);
		mcu.read(8'h04, 1'b0, 12'h000, d);
		check(8'(d[3]), 8'h00);
		repeat (20) @(negedge sys_clk);
		mcu.read(8'h04, 1'b0, 12'h000, d);
		check(8'(d[3]), 8'h01);
		mcu.write(8'h02, 12'h000, 8'h11);
		check(8'(busy), 8'h01);
		mcu.write(8'h02, 12'h000, 8'hB0);
		wait_st(1'b1);
		check(8'(suspended), 8'h01);
		mcu.read(8'h10, 1'b0, 12'h000, d);
		check(d, 8'h5A);
		mcu.read(8'h02, 1'b0, 12'h000, d);
		check(d, 8'hFF);
		mcu.write(8'h10, 12'h555, 8'hAA);
		check(8'(suspended), 8'h01);
		mcu.write(8'h02, 12'h000, 8'h30);
		check(8'({suspended, busy}), 8'h01);
		wait_st(1'b0);
		mcu.read(8'h02, 1'b0, 12'h000, d);
		check(8'(d[5]), 8'h00);
	endtask
	task automatic t_abort();
		mcu.cmd(8'h08, 8'h30);
		mcu.write(8'h08, 12'h000, 8'h11);
		check(8'(busy), 8'h00);
		mcu.cmd(8'h08, 8'h30);
		mcu.write(8'h08, 12'h000, 8'hB0);
		wait_st(1'b1);
		check(8'({suspended, busy}), 8'h02);
		mcu.write(8'h08, 12'h000, 8'hF0);
		check(8'({suspended, busy}), 8'h00);
		mcu.cmd(8'h01, 8'h30);
		check(8'(busy), 8'h00);
		erase_fail = 1'b1;
		mcu.cmd(8'h10, 8'h30);
		wait_st(1'b0);
		mcu.read(8'h10, 1'b0, 12'h000, d);
		check(8'(d[5]), 8'h01);
		erase_fail = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge sys_clk);
		t_regs();
		t_bulk();
		t_sector();
		t_abort();
		print_verdict();
	end
	// Watchdog
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
endmodule // test_flash_erase_sequencer
`default_nettype wire
